// ### common/fsp_pkg.sv
// Shared constants and types for the flame supervision and pause block.
package fsp_pkg;

	// Core clock rate and the timer tick derived from it.
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned TICK_MS = 1;
	localparam int unsigned TICK_CYCLES_DEF = (CLK_HZ / 1000) * TICK_MS;

	// Flame-loss timeout while paused, in seconds, then in ticks.
	localparam int unsigned FLAME_LOSS_S = 15;
	localparam int unsigned FLAME_LOSS_TICKS_DEF = FLAME_LOSS_S * 1000 / TICK_MS;

	// Longest pause, in minutes, then in ticks.
	localparam int unsigned PAUSE_MAX_MIN = 10;
	localparam int unsigned PAUSE_MAX_TICKS_DEF =
		PAUSE_MAX_MIN * 60 * 1000 / TICK_MS;

	// Monitoring latency budget of the functional flame input.
	localparam int unsigned MON_LATENCY_MS = 250;

	// Input filter time; must stay well inside the latency budget.
	localparam int unsigned FILT_MS = 20;
	localparam int unsigned FILT_TICKS_DEF = FILT_MS / TICK_MS;

	// Tolerated check-input disagreement, covering contact changeover.
	localparam int unsigned INV_TOL_MS = 100;
	localparam int unsigned INV_TOL_TICKS_DEF = INV_TOL_MS / TICK_MS;

	// Half period of the indicator flash pattern.
	localparam int unsigned FLASH_HALF_MS = 250;
	localparam int unsigned FLASH_TICKS_DEF = FLASH_HALF_MS / TICK_MS;

	// Flame-sensing configuration setting.
	localparam int unsigned CFG_W = 8;
	localparam logic [CFG_W-1:0] FLAME_SWITCH_SEL = 8'h01;

	// Bit positions of the pin group.
	localparam int unsigned PIN_N = 4;
	localparam int unsigned PIN_BTN = 0;
	localparam int unsigned PIN_FUNC = 1;
	localparam int unsigned PIN_CHECK = 2;
	localparam int unsigned PIN_RESET = 3;

	// Phase reported by the ignition sequencer.
	typedef enum logic [2:0] {
		FSP_PH_IDLE,
		FSP_PH_PURGE,
		FSP_PH_FIRST_SAFETY,
		FSP_PH_PILOT_PROVE,
		FSP_PH_MAIN_PROVE,
		FSP_PH_FIRING
	} fsp_phase_t;

	// Asynchronous pins from the flame switch and the front panel.
	typedef struct packed {
		logic op_reset;
		logic flame_check;
		logic flame_func;
		logic lockout_btn;
	} fsp_pins_t;

	// Latched lockout causes.
	typedef struct packed {
		logic inverse_check;
		logic pause_timeout;
		logic flame_loss;
	} fsp_cause_t;

	localparam fsp_cause_t CAUSE_NONE = 3'h0;

endpackage

// ### hdl/fsp_top.sv
// Ignition pause supervision and flame-switch monitoring with lockout.
`timescale 1ns/10ps
// What this block does
// (RULE1) In commissioning, a press in first safety time pauses the sequence.
// (RULE2) While paused, flame absent for 15 seconds raises a lockout.
// (RULE3) A pause lasting 10 minutes raises a lockout.
// (RULE4) A second press while paused resumes the sequence where it stopped.
// (RULE5) The lockout indicator flashes for the whole pause.
// (RULE6) Pause also allowed in pilot prove and main flame prove phases.
// (RULE7) Outside commissioning mode the button never pauses the sequence.
// (RULE8) Flame switch sensing is used only when the setting equals 1.
// (RULE9) In switch mode flame presence comes only from the functional input.
// (RULE10) Check input equal to the functional input raises a lockout.
// (RULE11) Functional input monitoring adds at most 250 milliseconds latency.
// (RULE12) The flame switch must respond within 750 milliseconds.
// (RULE13) The switch drives the check input opposite to the functional input.
// (RULE14) Each lockout latches, stops the sequence, waits for operator reset.
module fsp_top
	import fsp_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF,
	parameter int unsigned FLAME_LOSS_TICKS = FLAME_LOSS_TICKS_DEF,
	parameter int unsigned PAUSE_MAX_TICKS = PAUSE_MAX_TICKS_DEF,
	parameter int unsigned FILT_TICKS = FILT_TICKS_DEF,
	parameter int unsigned INV_TOL_TICKS = INV_TOL_TICKS_DEF,
	parameter int unsigned FLASH_TICKS = FLASH_TICKS_DEF,
	parameter int unsigned TICK_W = 18,
	parameter int unsigned CNT_W = 20
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire fsp_pins_t pins,
	input wire logic commission_mode,
	input wire logic [CFG_W-1:0] flame_cfg,
	input wire logic flame_det_in,
	input wire fsp_phase_t seq_phase,
	output logic seq_hold,
	output logic seq_stop,
	output logic lockout_led,
	output logic flame_present,
	output fsp_cause_t lockout_cause
);

	typedef enum logic {
		FSP_ST_ARMED,
		FSP_ST_PAUSED
	} fsp_state_t;

	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
	localparam logic [CNT_W-1:0] FILT_LAST = CNT_W'(FILT_TICKS - 1);
	localparam logic [CNT_W-1:0] LOSS_LAST = CNT_W'(FLAME_LOSS_TICKS - 1);
	localparam logic [CNT_W-1:0] PAUSE_LAST = CNT_W'(PAUSE_MAX_TICKS - 1);
	localparam logic [CNT_W-1:0] INV_LAST = CNT_W'(INV_TOL_TICKS - 1);
	localparam logic [CNT_W-1:0] FLASH_LAST = CNT_W'(FLASH_TICKS - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
	localparam logic [TICK_W-1:0] TICK_ZERO = TICK_W'(0);
	localparam logic [TICK_W-1:0] TICK_ONE = TICK_W'(1);

	logic [TICK_W-1:0] tick_cnt_reg;
	logic tick_reg;
	logic [PIN_N-1:0] pin_vec;
	logic [PIN_N-1:0] sync1_reg;
	logic [PIN_N-1:0] sync2_reg;
	logic [PIN_N-1:0] filt_reg;
	logic [PIN_N-1:0] filt_dly_reg;
	logic [CNT_W-1:0] filt_cnt_reg [PIN_N];
	logic btn_press;
	logic reset_press;
	logic switch_mode;
	logic flame_next;
	logic pause_ok;
	fsp_state_t state_reg;
	logic [CNT_W-1:0] loss_cnt_reg;
	logic [CNT_W-1:0] pause_cnt_reg;
	logic [CNT_W-1:0] inv_cnt_reg;
	logic [CNT_W-1:0] flash_cnt_reg;
	logic flash_reg;
	logic lockout_reg;
	fsp_cause_t cause_reg;
	fsp_cause_t cause_set;

	assign pin_vec = pins;

	// One tick per millisecond keeps the long timers to narrow counters.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			tick_cnt_reg <= TICK_ZERO;
			tick_reg <= 1'b0;
		end
		else if (tick_cnt_reg == TICK_LAST)
		begin
			tick_cnt_reg <= TICK_ZERO;
			tick_reg <= 1'b1;
		end
		else
		begin
			tick_cnt_reg <= tick_cnt_reg + TICK_ONE;
			tick_reg <= 1'b0;
		end
	end

	// Every pin is synchronised, then accepted only once stable for the
	// filter time, which bounces buttons and stays far below the budget.
	genvar gi;
	generate
		for (gi = 0; gi < PIN_N; gi++)
		begin : g_pin
			always_ff @(posedge core_clk)
			begin
				if (rst)
				begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
				end
				else
				begin
					sync1_reg[gi] <= pin_vec[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end

			always_ff @(posedge core_clk)
			begin
				if (rst)
				begin
					filt_reg[gi] <= 1'b0;
					filt_dly_reg[gi] <= 1'b0;
					filt_cnt_reg[gi] <= CNT_ZERO;
				end
				else
				begin
					filt_dly_reg[gi] <= filt_reg[gi];
					if (sync2_reg[gi] == filt_reg[gi])
						filt_cnt_reg[gi] <= CNT_ZERO;
					else if (tick_reg && filt_cnt_reg[gi] == FILT_LAST) // RULE11
					begin
						filt_reg[gi] <= sync2_reg[gi];
						filt_cnt_reg[gi] <= CNT_ZERO;
					end
					else if (tick_reg)
						filt_cnt_reg[gi] <= filt_cnt_reg[gi] + CNT_ONE;
				end
			end
		end
	endgenerate

	assign btn_press = filt_reg[PIN_BTN] && !filt_dly_reg[PIN_BTN];
	assign reset_press = filt_reg[PIN_RESET] && !filt_dly_reg[PIN_RESET];
	assign switch_mode = (flame_cfg == FLAME_SWITCH_SEL); // RULE8
	assign flame_next = switch_mode ? filt_reg[PIN_FUNC] : flame_det_in; // RULE9

	always_ff @(posedge core_clk)
	begin
		if (rst)
			flame_present <= 1'b0;
		else
			flame_present <= flame_next;
	end

	assign pause_ok = commission_mode && !lockout_reg && // RULE7
		(seq_phase == FSP_PH_FIRST_SAFETY || // RULE1
		seq_phase == FSP_PH_PILOT_PROVE || // RULE6
		seq_phase == FSP_PH_MAIN_PROVE);

	// Leaving commissioning or locking out drops the pause at once, so a
	// run-mode sequence can never be left frozen.
	always_ff @(posedge core_clk)
	begin
		if (rst)
			state_reg <= FSP_ST_ARMED;
		else
		begin
			case (state_reg)
				FSP_ST_ARMED:
					if (btn_press && pause_ok)
						state_reg <= FSP_ST_PAUSED; // RULE1
				FSP_ST_PAUSED:
					if (btn_press || !commission_mode || lockout_reg ||
						cause_set != CAUSE_NONE)
						state_reg <= FSP_ST_ARMED; // RULE4
				default:
					state_reg <= FSP_ST_ARMED;
			endcase
		end
	end

	// Flame-absent time while paused; any flame restarts it.
	always_ff @(posedge core_clk)
	begin
		if (rst || state_reg != FSP_ST_PAUSED || flame_present)
			loss_cnt_reg <= CNT_ZERO;
		else if (tick_reg && loss_cnt_reg != LOSS_LAST)
			loss_cnt_reg <= loss_cnt_reg + CNT_ONE;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst || state_reg != FSP_ST_PAUSED)
			pause_cnt_reg <= CNT_ZERO;
		else if (tick_reg && pause_cnt_reg != PAUSE_LAST)
			pause_cnt_reg <= pause_cnt_reg + CNT_ONE;
	end

	// Both inputs equal means the check is not the complement.
	always_ff @(posedge core_clk)
	begin
		if (rst || !switch_mode || filt_reg[PIN_FUNC] != filt_reg[PIN_CHECK])
			inv_cnt_reg <= CNT_ZERO;
		else if (tick_reg && inv_cnt_reg != INV_LAST)
			inv_cnt_reg <= inv_cnt_reg + CNT_ONE;
	end

	always_comb
	begin
		cause_set = CAUSE_NONE;
		cause_set.flame_loss = state_reg == FSP_ST_PAUSED && tick_reg &&
			!flame_present && loss_cnt_reg == LOSS_LAST; // RULE2
		cause_set.pause_timeout = state_reg == FSP_ST_PAUSED && tick_reg &&
			pause_cnt_reg == PAUSE_LAST; // RULE3
		cause_set.inverse_check = switch_mode && tick_reg &&
			inv_cnt_reg == INV_LAST; // RULE10
	end

	// A new cause in the reset cycle wins over the operator reset.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			lockout_reg <= 1'b0;
			cause_reg <= CAUSE_NONE;
		end
		else if (cause_set != CAUSE_NONE)
		begin
			lockout_reg <= 1'b1; // RULE14
			cause_reg <= (reset_press ? CAUSE_NONE : cause_reg) | cause_set;
		end
		else if (reset_press)
		begin
			lockout_reg <= 1'b0; // RULE14
			cause_reg <= CAUSE_NONE;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst || state_reg != FSP_ST_PAUSED)
		begin
			flash_cnt_reg <= CNT_ZERO;
			flash_reg <= 1'b0;
		end
		else if (tick_reg && flash_cnt_reg == FLASH_LAST)
		begin
			flash_cnt_reg <= CNT_ZERO;
			flash_reg <= !flash_reg; // RULE5
		end
		else if (tick_reg)
			flash_cnt_reg <= flash_cnt_reg + CNT_ONE;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			seq_hold <= 1'b0;
			seq_stop <= 1'b0;
			lockout_led <= 1'b0;
			lockout_cause <= CAUSE_NONE;
		end
		else
		begin
			seq_hold <= state_reg == FSP_ST_PAUSED;
			seq_stop <= lockout_reg; // RULE14
			lockout_led <= lockout_reg || (state_reg == FSP_ST_PAUSED && !flash_reg);
			lockout_cause <= cause_reg;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	sequence s_arm_press;
		state_reg == FSP_ST_ARMED && btn_press && pause_ok;
	endsequence

	sequence s_paused_press;
		state_reg == FSP_ST_PAUSED && btn_press;
	endsequence

	AST_PAUSE_ENTER: assert property (s_arm_press |=> ##1 seq_hold) // RULE1
		else $error("Pause not entered after eligible press.");
	AST_PAUSE_RELEASE: assert property (s_paused_press |=> ##1 !seq_hold) // RULE4
		else $error("Pause not released by second press.");
	AST_RUN_NO_PAUSE: assert property (!commission_mode ##1 // RULE7
		!commission_mode |=> !seq_hold)
		else $error("Sequence held outside commissioning mode.");
	AST_PHASE_GATE: assert property (state_reg == FSP_ST_ARMED && // RULE6
		btn_press && !(seq_phase inside {FSP_PH_FIRST_SAFETY,
		FSP_PH_PILOT_PROVE, FSP_PH_MAIN_PROVE}) |=> state_reg == FSP_ST_ARMED)
		else $error("Pause entered outside a prove phase.");
	AST_FLAME_LOSS: assert property (state_reg == FSP_ST_PAUSED && // RULE2
		tick_reg && !flame_present && loss_cnt_reg == LOSS_LAST
		|=> lockout_reg ##1 seq_stop && lockout_cause.flame_loss)
		else $error("Flame loss during pause did not lock out.");
	AST_PAUSE_TIMEOUT: assert property (state_reg == FSP_ST_PAUSED && // RULE3
		tick_reg && pause_cnt_reg == PAUSE_LAST
		|=> ##1 lockout_cause.pause_timeout)
		else $error("Pause timeout did not lock out.");
	AST_INVERSE: assert property (switch_mode && tick_reg && // RULE10
		inv_cnt_reg == INV_LAST |=> ##1 lockout_cause.inverse_check)
		else $error("Inverse check mismatch did not lock out.");
	AST_SOURCE: assert property (##1 flame_present == // RULE9
		$past(switch_mode ? filt_reg[PIN_FUNC] : flame_det_in))
		else $error("Flame presence taken from the wrong source.");
	AST_SELECT: assert property (!switch_mode // RULE8
		|=> inv_cnt_reg == CNT_ZERO)
		else $error("Flame switch checking active while not selected.");
	AST_LATCH: assert property (lockout_reg && !reset_press // RULE14
		|=> lockout_reg ##1 seq_stop && !seq_hold)
		else $error("Lockout cleared without operator reset.");
	AST_FLASH: assert property (state_reg == FSP_ST_PAUSED && // RULE5
		!lockout_reg && tick_reg && flash_cnt_reg == FLASH_LAST ##1
		state_reg == FSP_ST_PAUSED && !lockout_reg
		|=> lockout_led != $past(lockout_led))
		else $error("Indicator does not flash during pause.");
	AST_LATENCY: assert property (tick_reg && // RULE11
		sync2_reg[PIN_FUNC] != filt_reg[PIN_FUNC] &&
		filt_cnt_reg[PIN_FUNC] == FILT_LAST
		|=> filt_reg[PIN_FUNC] == $past(sync2_reg[PIN_FUNC]))
		else $error("Functional input filter exceeds its bound.");

endmodule

// ### tb/fsp_switch_model.sv
// Behavioural flame switch with changeover contact and panel buttons.
`timescale 1ns/10ps
module fsp_switch_model
	import fsp_pkg::*;
(
	input wire logic core_clk,
	input wire logic flame_on,
	input wire logic fault,
	input wire logic press,
	input wire logic op_rst,
	output fsp_pins_t pins
);
	initial pins = 4'h0;
	// One cycle of response sits far inside the switch delay budget.
	always @(posedge core_clk)
	begin
		pins.flame_func <= flame_on;
		// A welded contact makes the check side follow the functional side.
		pins.flame_check <= fault ? flame_on : ~flame_on;
		pins.lockout_btn <= press;
		pins.op_reset <= op_rst;
	end
endmodule

// ### tb/test_flame_supervision_pause.sv
// Self-checking bench for the pause supervision and flame monitoring.
`timescale 1ns/10ps
module test_flame_supervision_pause;
	import fsp_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic commission_mode = 1'b0;
	logic flame_det_in = 1'b0;
	logic flame_on = 1'b0;
	logic fault = 1'b0;
	logic press = 1'b0;
	logic op_rst = 1'b0;
	logic [CFG_W-1:0] flame_cfg = 8'h00;
	fsp_phase_t seq_phase = FSP_PH_IDLE;
	fsp_pins_t pins;
	logic seq_hold, seq_stop, lockout_led, flame_present;
	fsp_cause_t lockout_cause;
	int err_total = 0;
	int compares = 0;
	logic [31:0] seed = 32'hB6AA7E98;
	fsp_phase_t phs [4] = '{FSP_PH_FIRST_SAFETY, FSP_PH_PILOT_PROVE,
		FSP_PH_MAIN_PROVE, FSP_PH_PURGE};

	always #2.5 core_clk = ~core_clk;

	fsp_switch_model model (.core_clk(core_clk), .flame_on(flame_on),
		.fault(fault), .press(press), .op_rst(op_rst), .pins(pins));

	// Short tick and counts keep the run small; expectations scale with them.
	// The inverse tolerance keeps its default, so the built margin is tried.
	fsp_top #(.TICK_CYCLES(4), .FILT_TICKS(2), .FLAME_LOSS_TICKS(15),
		.PAUSE_MAX_TICKS(60), .FLASH_TICKS(2)) dut (
		.core_clk(core_clk), .rst(rst), .pins(pins),
		.commission_mode(commission_mode), .flame_cfg(flame_cfg),
		.flame_det_in(flame_det_in), .seq_phase(seq_phase),
		.seq_hold(seq_hold), .seq_stop(seq_stop), .lockout_led(lockout_led),
		.flame_present(flame_present), .lockout_cause(lockout_cause));

	function automatic logic rbit();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[0];
	endfunction

	function automatic logic sel(input int w);
		case (w)
			0: return seq_hold;
			1: return seq_stop;
			default: return flame_present;
		endcase
	endfunction

	task automatic stop_test();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1)
		begin
			err_total++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// Bounded wait for an output level; n returns the cycles spent.
	task automatic wt(input int w, input logic v, input int lim, output int n);
		n = 0;
		while (sel(w) !== v && n < lim)
		begin
			cyc(1);
			n++;
		end
		if (sel(w) !== v)
		begin
			err_total++;
			$display("[ERR] %0t wait ran out", $time);
			stop_test();
		end
	endtask

	task automatic btn(input logic v);
		@(posedge core_clk);
		press <= v;
	endtask

	task automatic clear_lockout();
		@(posedge core_clk);
		op_rst <= 1'b1;
		cyc(30);
		op_rst <= 1'b0;
		cyc(30);
		chk(seq_stop === 1'b0 && lockout_cause === CAUSE_NONE, "no clear");
	endtask

	initial
	begin
		int n;
		int t;
		logic v;
		cyc(12);
		rst <= 1'b0;
		cyc(2);
		// Other detector selected; switch pins must be ignored.
		flame_cfg <= 8'h02;
		repeat (8)
		begin
			v = rbit();
			flame_det_in <= v;
			flame_on <= ~v;
			cyc(2);
			chk(flame_present === v, "det path");
		end
		@(posedge core_clk);
		flame_cfg <= FLAME_SWITCH_SEL;
		repeat (6)
		begin
			v = rbit();
			flame_on <= v;
			flame_det_in <= ~v;
			cyc(1);
			wt(2, v, 1000, n);
			// Model, two sync flops, two filter ticks of four cycles, output.
			chk(n <= 12, "switch latency");
		end
		@(posedge core_clk);
		flame_on <= 1'b1;
		seq_phase <= FSP_PH_FIRST_SAFETY;
		wt(2, 1'b1, 1000, n);
		btn(1'b1);
		cyc(40);
		chk(seq_hold === 1'b0, "run mode paused");
		btn(1'b0);
		cyc(30);
		commission_mode <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			seq_phase <= phs[i];
			btn(1'b1);
			cyc(40);
			chk(seq_hold === (i < 3), "pause entry");
			btn(1'b0);
			t = 0;
			v = lockout_led;
			for (int k = 0; k < 48; k++)
			begin
				cyc(1);
				t += (lockout_led !== v);
				v = lockout_led;
			end
			if (i < 3)
			begin
				chk(t >= 4 && seq_hold === 1'b1, "no flash");
				btn(1'b1);
				wt(0, 1'b0, 40, n);
				chk(seq_stop === 1'b0, "resume stopped");
				btn(1'b0);
				cyc(30);
			end
			else
				chk(t == 0 && lockout_led === 1'b0, "led idle");
		end
		// Flame present throughout: only the overall pause limit fires.
		seq_phase <= FSP_PH_FIRST_SAFETY;
		btn(1'b1);
		wt(0, 1'b1, 40, n);
		wt(1, 1'b1, 300, n);
		chk(n >= 230 && n <= 254, "pause limit");
		cyc(1);
		chk(lockout_cause.pause_timeout === 1'b1, "cause");
		chk(seq_hold === 1'b0 && lockout_led === 1'b1, "lock");
		btn(1'b0);
		cyc(30);
		chk(seq_stop === 1'b1, "lockout not latched");
		clear_lockout();
		flame_on <= 1'b0;
		wt(2, 1'b0, 1000, n);
		btn(1'b1);
		wt(0, 1'b1, 40, n);
		wt(1, 1'b1, 100, n);
		chk(n >= 52 && n <= 70, "flame loss time");
		cyc(1);
		chk(lockout_cause.flame_loss === 1'b1, "loss cause");
		btn(1'b0);
		clear_lockout();
		// A welded contact leaves both inputs low.
		@(posedge core_clk);
		fault <= 1'b1;
		wt(1, 1'b1, 600, n);
		t = INV_TOL_TICKS_DEF * 4;
		chk(n >= t && n <= t + 16, "inverse time");
		cyc(1);
		chk(lockout_cause.inverse_check === 1'b1, "inverse cause");
		@(posedge core_clk);
		fault <= 1'b0;
		cyc(30);
		clear_lockout();
		stop_test();
	end
endmodule
